// ---- pkg/fwd_pkg.sv ----
package fwd_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TIMEOUT_MS = 800;
    // longest time: rounds down
    localparam longint unsigned TIMEOUT_CYCLES =
        (longint'(TIMEOUT_MS) * 64'd1000000) / longint'(CLK_PERIOD_NS);
    localparam int unsigned CNT_W = 27;

    // ---------------------------------------------------------------
    // reset values and reboot pulse length
    // ---------------------------------------------------------------
    localparam logic ARMED_RST = 1'b1;
    localparam logic CAUSE_RST = 1'b0;
    localparam logic [3:0] PULSE_LEN = 4'h4;

    typedef enum logic [1:0] {
        FWD_IDLE,
        FWD_COUNT,
        FWD_FIRE
    } fwd_state_t;

endpackage : fwd_pkg

// ---- src/fwd_watchdog.sv ----
`timescale 1ns/1ns
// How it works
// - timeout is fixed at 0.8 s; nothing in software changes it.
// - after power-on reset the watchdog is armed and counting.
// - no kick within 0.8 s of arming or last kick forces a reboot.
// - separate arm, disarm and kick commands; disarmed never reboots.
// - a flag surviving the reboot tells whether the watchdog caused it.
module fwd_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES = 32'(fwd_pkg::TIMEOUT_CYCLES)
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic arm_watchdog_cmd_i,
    input wire logic disarm_watchdog_cmd_i,
    input wire logic kick_watchdog_cmd_i,
    input wire logic cause_clear_i,
    output logic armed_o,
    output logic reboot_o,
    output logic last_reboot_cause_query_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    fwd_pkg::fwd_state_t state_ff;
    logic [fwd_pkg::CNT_W-1:0] count_ff;
    logic [3:0] pulse_ff;
    logic expire;

    localparam logic [fwd_pkg::CNT_W-1:0] LAST = fwd_pkg::CNT_W'(TIMEOUT_CYCLES - 1);

    assign expire = (state_ff == fwd_pkg::FWD_COUNT) && (count_ff == LAST)
        && !kick_watchdog_cmd_i && !disarm_watchdog_cmd_i;

    // ---------------------------------------------------------------
    // arming and firing
    // ---------------------------------------------------------------
    // disarm beats arm if both arrive together: the safe way to lose a race
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= fwd_pkg::FWD_COUNT;
        end
        else
        begin
            unique case (state_ff)
                fwd_pkg::FWD_IDLE:
                begin
                    if (arm_watchdog_cmd_i && !disarm_watchdog_cmd_i)
                    begin
                        state_ff <= fwd_pkg::FWD_COUNT;
                    end
                end
                fwd_pkg::FWD_COUNT:
                begin
                    if (disarm_watchdog_cmd_i)
                    begin
                        state_ff <= fwd_pkg::FWD_IDLE;
                    end
                    else if (expire)
                    begin
                        state_ff <= fwd_pkg::FWD_FIRE;
                    end
                end
                fwd_pkg::FWD_FIRE:
                begin
                    if (pulse_ff == 4'h1)
                    begin
                        state_ff <= fwd_pkg::FWD_COUNT;
                    end
                end
                default:
                begin
                    state_ff <= fwd_pkg::FWD_COUNT;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // timeout counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_ff <= '0;
        end
        else if (state_ff != fwd_pkg::FWD_COUNT || kick_watchdog_cmd_i
            || arm_watchdog_cmd_i)
        begin
            count_ff <= '0;
        end
        else if (count_ff != LAST)
        begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // reboot pulse and cause flag
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pulse_ff <= '0;
            reboot_o <= 1'b0;
        end
        else if (expire)
        begin
            pulse_ff <= fwd_pkg::PULSE_LEN;
            reboot_o <= 1'b1;
        end
        else if (pulse_ff != 4'h0)
        begin
            pulse_ff <= pulse_ff - 1'b1;
            reboot_o <= (pulse_ff != 4'h1);
        end
    end

    // the reboot pulse leaves this flag set; only reset_n_i or cause_clear_i clears it; the set wins a clear
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            last_reboot_cause_query_o <= fwd_pkg::CAUSE_RST;
        end
        else if (expire)
        begin
            last_reboot_cause_query_o <= 1'b1;
        end
        else if (cause_clear_i)
        begin
            last_reboot_cause_query_o <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // armed flag
    // ---------------------------------------------------------------
    // built from the same inputs as the state, so it never lags the state by a cycle
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            armed_o <= fwd_pkg::ARMED_RST;
        end
        else
        begin
            armed_o <= (state_ff == fwd_pkg::FWD_IDLE)
                ? (arm_watchdog_cmd_i && !disarm_watchdog_cmd_i)
                : !(state_ff == fwd_pkg::FWD_COUNT && disarm_watchdog_cmd_i);
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence kick_s;
        kick_watchdog_cmd_i && state_ff == fwd_pkg::FWD_COUNT && !disarm_watchdog_cmd_i;
    endsequence

    // counting with no restart pending: exactly one step per clock
    sequence plain_count_s;
        state_ff == fwd_pkg::FWD_COUNT && !kick_watchdog_cmd_i && !arm_watchdog_cmd_i
            && count_ff != LAST;
    endsequence

    sequence arm_s;
        state_ff == fwd_pkg::FWD_IDLE && arm_watchdog_cmd_i && !disarm_watchdog_cmd_i;
    endsequence

    // high for the whole pulse, then low again
    sequence reboot_pulse_s;
        reboot_o [*4] ##1 !reboot_o;
    endsequence

    restart_on_kick_a: assert property (kick_s |=> count_ff == '0)
        else $error("kick did not restart the count");

    expire_fires_a: assert property (expire |=> reboot_o && last_reboot_cause_query_o)
        else $error("expiry did not reboot");

    // a skipped or stuck step would move the timeout away from its fixed length
    timeout_value_a: assert property (plain_count_s
        |=> count_ff == $past(count_ff) + 1'b1)
        else $error("count skipped a step");

    disarmed_quiet_a: assert property (state_ff == fwd_pkg::FWD_IDLE
        |=> !$rose(reboot_o))
        else $error("disarmed watchdog rebooted");

    // a reboot already under way runs to its end; a disarm during it is lost
    disarm_takes_a: assert property (disarm_watchdog_cmd_i
        && state_ff != fwd_pkg::FWD_FIRE |=> !armed_o)
        else $error("disarm ignored");

    arm_takes_a: assert property (arm_s |=> armed_o && count_ff == '0)
        else $error("arm ignored");

    armed_tracks_a: assert property (armed_o == (state_ff != fwd_pkg::FWD_IDLE))
        else $error("armed flag disagrees with state");

    pulse_length_a: assert property ($rose(reboot_o) |-> reboot_pulse_s)
        else $error("reboot pulse length wrong");

    cause_sticky_a: assert property (last_reboot_cause_query_o && !cause_clear_i
        |=> last_reboot_cause_query_o)
        else $error("cause flag lost");

    cause_clears_a: assert property (cause_clear_i && !expire
        |=> !last_reboot_cause_query_o)
        else $error("cause flag not cleared");

    no_early_fire_a: assert property ($rose(reboot_o) |-> $past(count_ff) == LAST)
        else $error("reboot before timeout");

endmodule : fwd_watchdog

// ---- sim/fwd_watchdog_test.sv ----
`timescale 1ns/1ns
module fwd_watchdog_test;
    // ---------------------------------------------------------------
    // short timeout keeps the run brief
    // ---------------------------------------------------------------
    localparam int T = 20;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic arm = 1'b0;
    logic dis = 1'b0;
    logic kick = 1'b0;
    logic clr = 1'b0;
    logic armed_o;
    logic reboot_o;
    logic cause_o;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk_i = ~clk_i;
    fwd_watchdog #(.TIMEOUT_CYCLES(T)) uut (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .arm_watchdog_cmd_i(arm),
        .disarm_watchdog_cmd_i(dis),
        .kick_watchdog_cmd_i(kick),
        .cause_clear_i(clr),
        .armed_o(armed_o),
        .reboot_o(reboot_o),
        .last_reboot_cause_query_o(cause_o)
    );
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc > 2000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask : pulse
    // reboot must stay low for n cycles
    task automatic quiet(input int n);
        repeat (n)
        begin
            @(negedge clk_i);
            check(reboot_o, 1'b0);
        end
    endtask : quiet
    // reboot must come within lim cycles and last exactly 4
    task automatic expect_fire(input int lim);
        int k;
        int w;
        k = 0;
        w = 0;
        while (reboot_o !== 1'b1 && k < lim)
        begin
            @(negedge clk_i);
            k++;
        end
        check(reboot_o, 1'b1);
        while (reboot_o === 1'b1 && w < 8)
        begin
            @(negedge clk_i);
            w++;
        end
        check(w == 4, 1'b1);
        check(cause_o, 1'b1);
        check(armed_o, 1'b1);
    endtask : expect_fire
    // armed from power-on with no software action
    task automatic power_on_fire();
        check(armed_o, 1'b1);
        check(cause_o, 1'b0);
        reset_n_i = 1'b1;
        quiet(T - 3);
        expect_fire(5);
        check(cause_o, 1'b1);
    endtask : power_on_fire
    // firmware kicks, then the user program; an arm while armed restarts too
    task automatic kicks_hold_off();
        repeat (3)
        begin
            quiet(T - 5);
            pulse(kick);
        end
        repeat (2)
        begin
            quiet(T - 5);
            pulse(kick);
        end
        quiet(T - 5);
        pulse(arm);
        check(armed_o, 1'b1);
        quiet(T - 3);
        expect_fire(5);
        pulse(clr);
        check(cause_o, 1'b0);
    endtask : kicks_hold_off
    // disarmed never reboots, kicks ignored, disarm beats a same-cycle arm
    task automatic disarm_quiet();
        pulse(dis);
        check(armed_o, 1'b0);
        pulse(kick);
        quiet(3 * T);
        @(negedge clk_i);
        arm = 1'b1;
        dis = 1'b1;
        @(negedge clk_i);
        arm = 1'b0;
        dis = 1'b0;
        check(armed_o, 1'b0);
    endtask : disarm_quiet
    // re-arm, then a clear in the expiring cycle: the set must win
    task automatic rearm_clear_race();
        pulse(arm);
        check(armed_o, 1'b1);
        quiet(T - 3);
        @(negedge clk_i);
        check(reboot_o, 1'b0);
        @(negedge clk_i);
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        check(cause_o, 1'b1);
        expect_fire(1);
    endtask : rearm_clear_race
    // a second power-on reset clears the cause flag and arms again
    task automatic power_cycle();
        @(negedge clk_i);
        reset_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        check(cause_o, 1'b0);
        check(armed_o, 1'b1);
        check(reboot_o, 1'b0);
        reset_n_i = 1'b1;
        quiet(T - 3);
        expect_fire(5);
    endtask : power_cycle
    initial
    begin
        repeat (16) @(negedge clk_i);
        power_on_fire();
        kicks_hold_off();
        disarm_quiet();
        rearm_clear_race();
        power_cycle();
        report_and_stop();
    end
endmodule : fwd_watchdog_test
